// ===== switch_port_config_regs.sv
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module switch_port_config_regs (
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite slave
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Priority lookups
  input wire logic [2:0] hostTxHeaderPrio,
  output logic [2:0] hostTxQueuePrio,
  input wire logic [2:0] hostRxPacketPrio,
  output logic [2:0] hostRxHeaderPrio,
  input wire logic [2:0] port1TxHeaderPrio,
  output logic [2:0] port1TxQueuePrio,
  // Source tag insertion
  input wire logic fromPort2,
  output logic [7:0] infoWordSourceField,
  // Frame classification
  input port_cfg_pkg::frame_end_type frameEnd,
  output port_cfg_pkg::frame_class_type frameClass,
  output logic frameClassValid,
  // Static configuration out
  output logic [13:0] rxMaxFrameLen,
  output logic [4:0] port1TxBlocks,
  output logic [5:0] port1RxBlocks,
  output port_cfg_pkg::vlan_tag_type port1DefaultTag,
  output logic [47:0] stationAddr,
  output logic [15:0] syncMsgKindEnable
);
  import port_cfg_pkg::*;

  localparam int NUM_REGS = 10;

  logic [31:0] cfg_reg [NUM_REGS];
  logic [31:0] cfg_next [NUM_REGS];
  logic [31:0] mask [NUM_REGS];
  logic [31:0] rst [NUM_REGS];
  logic [5:0] ofs [NUM_REGS];

  // Map tables kept as constants beside the storage
  assign ofs[0] = HOST_TX_PRIO_MAP_OFS;
  assign ofs[1] = HOST_SOURCE_ID_OFS;
  assign ofs[2] = HOST_RX_PRIO_MAP_OFS;
  assign ofs[3] = HOST_RX_MAX_FRAME_LEN_OFS;
  assign ofs[4] = PORT1_FIFO_BLOCK_ALLOC_OFS;
  assign ofs[5] = PORT1_DEFAULT_VLAN_OFS;
  assign ofs[6] = PORT1_TX_PRIO_MAP_OFS;
  assign ofs[7] = MAC1_STATION_ADDR_LOW_OFS;
  assign ofs[8] = MAC1_STATION_ADDR_HIGH_OFS;
  assign ofs[9] = PORT1_TIMESYNC_CONTROL_OFS;
  assign mask[0] = PRIO_MAP_MASK;
  assign mask[1] = SOURCE_ID_MASK;
  assign mask[2] = PRIO_MAP_MASK;
  assign mask[3] = MAX_LEN_MASK;
  assign mask[4] = BLOCK_ALLOC_MASK;
  assign mask[5] = VLAN_MASK;
  assign mask[6] = PRIO_MAP_MASK;
  assign mask[7] = ADDR_LOW_MASK;
  assign mask[8] = ADDR_HIGH_MASK;
  assign mask[9] = TIMESYNC_MASK;
  assign rst[0] = HOST_TX_PRIO_MAP_RST;
  assign rst[1] = ZERO_RST;
  assign rst[2] = HOST_RX_PRIO_MAP_RST;
  assign rst[3] = MAX_LEN_RST;
  assign rst[4] = BLOCK_ALLOC_RST;
  assign rst[5] = ZERO_RST;
  assign rst[6] = PORT1_TX_PRIO_MAP_RST;
  assign rst[7] = ZERO_RST;
  assign rst[8] = ZERO_RST;
  assign rst[9] = ZERO_RST;

  // Write channel state: address and data captured independently
  logic awReady_reg, awReady_next; // Low while an address is held
  logic wReady_reg, wReady_next; // Low while write data is held
  logic [5:0] wAddr_reg, wAddr_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0] wStrb_reg, wStrb_next;
  logic bValid_reg, bValid_next;
  logic [1:0] bResp_reg, bResp_next;
  logic doWrite;
  logic writeHit;

  assign doWrite = !awReady_reg && !wReady_reg && !bValid_reg;

  always_comb begin
    writeHit = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (wAddr_reg == ofs[i]) begin
        writeHit = 1'b1;
      end
    end
  end

  // Write handshake; a new address and data are taken while the response is up, but the write waits until it clears
  always_comb begin
    awReady_next = awReady_reg;
    wReady_next = wReady_reg;
    wAddr_next = wAddr_reg;
    wData_next = wData_reg;
    wStrb_next = wStrb_reg;
    bValid_next = bValid_reg;
    bResp_next = bResp_reg;
    if (awvalid && awReady_reg) begin
      awReady_next = 1'b0;
      wAddr_next = awaddr;
    end
    if (wvalid && wReady_reg) begin
      wReady_next = 1'b0;
      wData_next = wdata;
      wStrb_next = wstrb;
    end
    if (doWrite) begin
      awReady_next = 1'b1;
      wReady_next = 1'b1;
      bValid_next = 1'b1;
      bResp_next = writeHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bValid_reg && bready) begin
      bValid_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      awReady_reg <= 1'b1;
      wReady_reg <= 1'b1;
      wAddr_reg <= 6'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
    end else begin
      awReady_reg <= awReady_next;
      wReady_reg <= wReady_next;
      wAddr_reg <= wAddr_next;
      wData_reg <= wData_next;
      wStrb_reg <= wStrb_next;
      bValid_reg <= bValid_next;
      bResp_reg <= bResp_next;
    end
  end

  assign awready = awReady_reg;
  assign wready = wReady_reg;
  assign bvalid = bValid_reg;
  assign bresp = bResp_reg;

  // Register storage, one generate entry per register
  for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
    logic [31:0] strbMask;
    always_comb begin
      strbMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}}, {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
      cfg_next[r] = cfg_reg[r];
      if (doWrite && wAddr_reg == ofs[r]) begin
        // Reserved bits never take a written one
        cfg_next[r] = ((cfg_reg[r] & ~strbMask) | (wData_reg & strbMask)) & mask[r];
      end
    end
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        cfg_reg[r] <= rst[r];
      end else begin
        cfg_reg[r] <= cfg_next[r];
      end
    end
  end

  // Frame class counters, read back as status
  logic [7:0] longCount_reg, longCount_next;
  logic [7:0] oversizeCount_reg, oversizeCount_next;
  logic [7:0] jabberCount_reg, jabberCount_next;

  // Read channel
  logic rValid_reg, rValid_next, arReady_reg, arReady_next;
  logic [31:0] rData_reg, rData_next;
  logic [1:0] rResp_reg, rResp_next;
  logic [31:0] readWord;
  logic readHit;

  always_comb begin
    readWord = 32'h00000000;
    readHit = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (araddr == ofs[i]) begin
        readWord = cfg_reg[i];
        readHit = 1'b1;
      end
    end
    if (araddr == FRAME_CHECK_STATUS_OFS) begin
      readWord = {8'h00, jabberCount_reg, oversizeCount_reg, longCount_reg};
      readHit = 1'b1;
    end
  end

  always_comb begin
    rValid_next = rValid_reg;
    rData_next = rData_reg;
    rResp_next = rResp_reg;
    if (arvalid && arready) begin
      rValid_next = 1'b1;
      rData_next = readWord;
      rResp_next = readHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_reg && rready) begin
      rValid_next = 1'b0;
    end
    arReady_next = !rValid_next; // Own flop so the port never sees an inverter
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rValid_reg <= 1'b0;
      arReady_reg <= 1'b1;
      rData_reg <= 32'h00000000;
      rResp_reg <= RESP_OKAY;
    end else begin
      rValid_reg <= rValid_next;
      arReady_reg <= arReady_next;
      rData_reg <= rData_next;
      rResp_reg <= rResp_next;
    end
  end

  assign arready = arReady_reg;
  assign rvalid = rValid_reg;
  assign rdata = rData_reg;
  assign rresp = rResp_reg;

  // Registered lookups; one cycle of latency from the packet side
  logic [2:0] hostTxQueuePrio_reg, hostTxQueuePrio_next;
  logic [2:0] hostRxHeaderPrio_reg, hostRxHeaderPrio_next;
  logic [2:0] port1TxQueuePrio_reg, port1TxQueuePrio_next;
  logic [7:0] sourceField_reg, sourceField_next;

  always_comb begin
    hostTxQueuePrio_next = cfg_reg[0][PRIO_FIELD_STRIDE*hostTxHeaderPrio +: 3];
    hostRxHeaderPrio_next = cfg_reg[2][PRIO_FIELD_STRIDE*hostRxPacketPrio +: 3];
    port1TxQueuePrio_next = cfg_reg[6][PRIO_FIELD_STRIDE*port1TxHeaderPrio +: 3];
    sourceField_next = fromPort2 ? cfg_reg[1][CHAN_B_TAG_LSB +: 8]
                                 : cfg_reg[1][7:0];
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hostTxQueuePrio_reg <= 3'h0;
      hostRxHeaderPrio_reg <= 3'h0;
      port1TxQueuePrio_reg <= 3'h0;
      sourceField_reg <= 8'h00;
    end else begin
      hostTxQueuePrio_reg <= hostTxQueuePrio_next;
      hostRxHeaderPrio_reg <= hostRxHeaderPrio_next;
      port1TxQueuePrio_reg <= port1TxQueuePrio_next;
      sourceField_reg <= sourceField_next;
    end
  end

  assign hostTxQueuePrio = hostTxQueuePrio_reg;
  assign hostRxHeaderPrio = hostRxHeaderPrio_reg;
  assign port1TxQueuePrio = port1TxQueuePrio_reg;
  assign infoWordSourceField = sourceField_reg;

  // Frame classification against the programmed maximum
  frame_class_type class_reg, class_next;
  logic classValid_reg, classValid_next;
  logic frameBad;

  always_comb begin
    frameBad = frameEnd.crcError || frameEnd.codeError || frameEnd.alignError;
    class_next.isLong = frameEnd.byteCount > cfg_reg[3][13:0];
    class_next.isOversized = class_next.isLong && !frameBad;
    class_next.isJabber = class_next.isLong && frameBad;
    classValid_next = frameEnd.valid;
    longCount_next = longCount_reg;
    oversizeCount_next = oversizeCount_reg;
    jabberCount_next = jabberCount_reg;
    // Saturating counters so software never sees a wrap
    if (frameEnd.valid && class_next.isLong && longCount_reg != 8'hff) begin
      longCount_next = longCount_reg + 8'h01;
    end
    if (frameEnd.valid && class_next.isOversized && oversizeCount_reg != 8'hff) begin
      oversizeCount_next = oversizeCount_reg + 8'h01;
    end
    if (frameEnd.valid && class_next.isJabber && jabberCount_reg != 8'hff) begin
      jabberCount_next = jabberCount_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      class_reg <= '0;
      classValid_reg <= 1'b0;
      longCount_reg <= 8'h00;
      oversizeCount_reg <= 8'h00;
      jabberCount_reg <= 8'h00;
    end else begin
      class_reg <= classValid_next ? class_next : '0;
      classValid_reg <= classValid_next;
      longCount_reg <= longCount_next;
      oversizeCount_reg <= oversizeCount_next;
      jabberCount_reg <= jabberCount_next;
    end
  end

  assign frameClass = class_reg;
  assign frameClassValid = classValid_reg;

  // Static fields straight from storage flops
  assign rxMaxFrameLen = cfg_reg[3][13:0];
  assign port1TxBlocks = cfg_reg[4][TX_BLOCKS_LSB +: 5];
  assign port1RxBlocks = cfg_reg[4][5:0];
  assign port1DefaultTag = cfg_reg[5][15:0];
  // Byte 0 is address bits 7-0 and sits high in the low word
  assign stationAddr = {cfg_reg[8][7:0], cfg_reg[8][15:8], cfg_reg[8][23:16],
                        cfg_reg[8][31:24], cfg_reg[7][7:0], cfg_reg[7][15:8]};
  assign syncMsgKindEnable = cfg_reg[9][SYNC_KIND_LSB +: 16];

  // Checks
  sequence write_taken_s;
    doWrite && writeHit;
  endsequence

  sequence response_up_s;
    ##1 bvalid && bresp == RESP_OKAY;
  endsequence

  write_resp_a: assert property (@(posedge clk) disable iff (!reset_n)
    write_taken_s |-> response_up_s) else $error("write response missing");

  host_tx_map_a: assert property (@(posedge clk) disable iff (!reset_n)
    hostTxQueuePrio == $past(cfg_reg[0][PRIO_FIELD_STRIDE*hostTxHeaderPrio +: 3]))
    else $error("host tx map wrong");

  host_rx_map_a: assert property (@(posedge clk) disable iff (!reset_n)
    hostRxHeaderPrio == $past(cfg_reg[2][PRIO_FIELD_STRIDE*hostRxPacketPrio +: 3]))
    else $error("host rx map wrong");

  port1_map_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(port1TxHeaderPrio) == 3'h7 |-> port1TxQueuePrio == $past(cfg_reg[6][30:28]))
    else $error("port1 map wrong");

  source_tag_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(fromPort2) |-> infoWordSourceField == $past(cfg_reg[1][15:8]))
    else $error("channel b tag wrong");

  source_tag_b_a: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(fromPort2) |-> infoWordSourceField == $past(cfg_reg[1][7:0]))
    else $error("channel a tag wrong");

  long_frame_a: assert property (@(posedge clk) disable iff (!reset_n)
    frameEnd.valid |=> frameClass.isLong == ($past(frameEnd.byteCount) > $past(rxMaxFrameLen)))
    else $error("long class wrong");

  oversize_a: assert property (@(posedge clk) disable iff (!reset_n)
    frameClass.isOversized |-> frameClass.isLong && !frameClass.isJabber)
    else $error("oversize class wrong");

  jabber_a: assert property (@(posedge clk) disable iff (!reset_n)
    frameEnd.valid && (frameEnd.crcError || frameEnd.codeError) |=>
    frameClass.isJabber == frameClass.isLong) else $error("jabber class wrong");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_reg[4][8:6] == 3'h0 && cfg_reg[7][31:16] == 16'h0000)
    else $error("reserved bits set");

  max_len_reset_a: assert property (@(posedge clk)
    !reset_n |=> rxMaxFrameLen == MAX_LEN_RST[13:0]) else $error("max length reset wrong");

endmodule : switch_port_config_regs

// ===== port_cfg_pkg.sv
package port_cfg_pkg;

  // Register byte offsets
  localparam logic [5:0] HOST_TX_PRIO_MAP_OFS = 6'h00;
  localparam logic [5:0] HOST_SOURCE_ID_OFS = 6'h04;
  localparam logic [5:0] HOST_RX_PRIO_MAP_OFS = 6'h08;
  localparam logic [5:0] HOST_RX_MAX_FRAME_LEN_OFS = 6'h0c;
  localparam logic [5:0] PORT1_FIFO_BLOCK_ALLOC_OFS = 6'h10;
  localparam logic [5:0] PORT1_DEFAULT_VLAN_OFS = 6'h14;
  localparam logic [5:0] PORT1_TX_PRIO_MAP_OFS = 6'h18;
  localparam logic [5:0] MAC1_STATION_ADDR_LOW_OFS = 6'h1c;
  localparam logic [5:0] MAC1_STATION_ADDR_HIGH_OFS = 6'h20;
  localparam logic [5:0] PORT1_TIMESYNC_CONTROL_OFS = 6'h24;
  localparam logic [5:0] FRAME_CHECK_STATUS_OFS = 6'h28;

  // Writable-bit masks; reserved bits read zero
  localparam logic [31:0] PRIO_MAP_MASK = 32'h77777777;
  localparam logic [31:0] SOURCE_ID_MASK = 32'h0000ffff;
  localparam logic [31:0] MAX_LEN_MASK = 32'h00003fff;
  localparam logic [31:0] BLOCK_ALLOC_MASK = 32'h00003e3f;
  localparam logic [31:0] VLAN_MASK = 32'h0000ffff;
  localparam logic [31:0] ADDR_LOW_MASK = 32'h0000ffff;
  localparam logic [31:0] ADDR_HIGH_MASK = 32'hffffffff;
  localparam logic [31:0] TIMESYNC_MASK = 32'hffff0000;

  // Reset values
  localparam logic [31:0] HOST_TX_PRIO_MAP_RST = 32'h76543210;
  localparam logic [31:0] HOST_RX_PRIO_MAP_RST = 32'h76543210;
  localparam logic [31:0] PORT1_TX_PRIO_MAP_RST = 32'h33221001;
  localparam logic [31:0] MAX_LEN_RST = 32'h000005ee;
  localparam logic [31:0] BLOCK_ALLOC_RST = 32'h00000001;
  localparam logic [31:0] ZERO_RST = 32'h00000000;

  // Field positions and the length ceiling
  localparam int PRIO_FIELD_STRIDE = 4;
  localparam int CHAN_B_TAG_LSB = 8;
  localparam int TX_BLOCKS_LSB = 9;
  localparam int SYNC_KIND_LSB = 16;
  localparam logic [13:0] MAX_LEN_LIMIT = 14'd9604;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [2:0] prio;
    logic canonical;
    logic [11:0] vlanId;
  } vlan_tag_type;

  typedef struct packed {
    logic valid;
    logic [13:0] byteCount;
    logic crcError;
    logic codeError;
    logic alignError;
  } frame_end_type;

  typedef struct packed {
    logic isLong;
    logic isOversized;
    logic isJabber;
  } frame_class_type;

endpackage : port_cfg_pkg

// ===== switch_port_config_regs_tb.sv
`timescale 1ns/1ps
module switch_port_config_regs_tb;
  import port_cfg_pkg::*;
  logic clk, reset_n;
  logic [5:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] hostTxHeaderPrio, hostTxQueuePrio, hostRxPacketPrio, hostRxHeaderPrio;
  logic [2:0] port1TxHeaderPrio, port1TxQueuePrio;
  logic fromPort2, frameClassValid;
  logic [7:0] infoWordSourceField;
  frame_end_type frameEnd;
  frame_class_type frameClass;
  logic [13:0] rxMaxFrameLen;
  logic [4:0] port1TxBlocks;
  logic [5:0] port1RxBlocks;
  vlan_tag_type port1DefaultTag;
  logic [47:0] stationAddr;
  logic [15:0] syncMsgKindEnable;
  int nFail = 0;
  int totalChecks = 0;
  logic [31:0] rng = 32'h00000f91;
  logic [33:0] readQ[$];
  logic [1:0] respQ[$];
  frame_class_type classQ[$];
  logic [7:0] nLong = 8'h00, nOvs = 8'h00, nJab = 8'h00;
  logic [31:0] v;
  logic [31:0] vals[10];
  logic [5:0] offs[10] = '{HOST_TX_PRIO_MAP_OFS, HOST_SOURCE_ID_OFS, HOST_RX_PRIO_MAP_OFS,
    HOST_RX_MAX_FRAME_LEN_OFS, PORT1_FIFO_BLOCK_ALLOC_OFS, PORT1_DEFAULT_VLAN_OFS,
    PORT1_TX_PRIO_MAP_OFS, MAC1_STATION_ADDR_LOW_OFS, MAC1_STATION_ADDR_HIGH_OFS,
    PORT1_TIMESYNC_CONTROL_OFS};
  logic [31:0] masks[10] = '{PRIO_MAP_MASK, SOURCE_ID_MASK, PRIO_MAP_MASK, MAX_LEN_MASK,
    BLOCK_ALLOC_MASK, VLAN_MASK, PRIO_MAP_MASK, ADDR_LOW_MASK, ADDR_HIGH_MASK, TIMESYNC_MASK};
  logic [31:0] rsts[10] = '{HOST_TX_PRIO_MAP_RST, ZERO_RST, HOST_RX_PRIO_MAP_RST, MAX_LEN_RST,
    BLOCK_ALLOC_RST, ZERO_RST, PORT1_TX_PRIO_MAP_RST, ZERO_RST, ZERO_RST, ZERO_RST};
  // Length in 16-3, error flags crc, code, align; back to back around a max of 100
  logic [16:0] frames[7] = '{{14'd100, 3'b000}, {14'd101, 3'b000}, {14'd101, 3'b100},
    {14'd101, 3'b010}, {14'd101, 3'b001}, {14'd50, 3'b100}, {14'd9604, 3'b000}};

  switch_port_config_regs switch_port_config_regs_i (.clk(clk), .reset_n(reset_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .hostTxHeaderPrio(hostTxHeaderPrio),
    .hostTxQueuePrio(hostTxQueuePrio), .hostRxPacketPrio(hostRxPacketPrio),
    .hostRxHeaderPrio(hostRxHeaderPrio), .port1TxHeaderPrio(port1TxHeaderPrio),
    .port1TxQueuePrio(port1TxQueuePrio), .fromPort2(fromPort2),
    .infoWordSourceField(infoWordSourceField), .frameEnd(frameEnd), .frameClass(frameClass),
    .frameClassValid(frameClassValid), .rxMaxFrameLen(rxMaxFrameLen),
    .port1TxBlocks(port1TxBlocks), .port1RxBlocks(port1RxBlocks),
    .port1DefaultTag(port1DefaultTag), .stationAddr(stationAddr),
    .syncMsgKindEnable(syncMsgKindEnable));

  // Free-running clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] nextRand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : nextRand

  task automatic chkBus(input logic [33:0] got, input logic [33:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkBus

  task automatic chkOut(input logic [47:0] got, input logic [47:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkOut

  task automatic tally_and_finish();
    // Notes still queued mean a result never came
    chkOut(48'(readQ.size() + respQ.size() + classQ.size()), 48'h0);
    $display("checks=%0d mismatches=%0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // Address and data offered together, each dropped on its own handshake
  task automatic axiWrite(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] r);
    bit awDone, wDone, aHs, wHs;
    respQ.push_back(r);
    awDone = 0;
    wDone = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(negedge clk);
      aHs = awvalid && awready;
      wHs = wvalid && wready;
      @(posedge clk);
      if (aHs) begin
        awvalid <= 1'b0;
        awDone = 1;
      end
      if (wHs) begin
        wvalid <= 1'b0;
        wDone = 1;
      end
    end
    do @(negedge clk); while (!bvalid);
    @(posedge clk);
    bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [5:0] a, input logic [33:0] e);
    readQ.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    @(posedge clk);
    rready <= 1'b0;
  endtask : axiRead

  // Lookups answer one cycle after the input edge
  task automatic prioSweep(input logic [31:0] tx, rx, p1, sid);
    for (int n = 0; n < 8; n++) begin
      @(posedge clk);
      hostTxHeaderPrio <= 3'(n);
      hostRxPacketPrio <= 3'(n);
      port1TxHeaderPrio <= 3'(n);
      fromPort2 <= n[0];
      @(posedge clk);
      @(negedge clk);
      chkOut(48'(hostTxQueuePrio), 48'(tx[4*n +: 3]));
      chkOut(48'(hostRxHeaderPrio), 48'(rx[4*n +: 3]));
      chkOut(48'(port1TxQueuePrio), 48'(p1[4*n +: 3]));
      chkOut(48'(infoWordSourceField), 48'(n[0] ? sid[15:8] : sid[7:0]));
    end
  endtask : prioSweep

  // Expected class reckoned against the maximum held in vals[3]
  task automatic sendFrame(input logic [16:0] f);
    logic l, err;
    l = f[16:3] > vals[3][13:0];
    err = |f[2:0];
    classQ.push_back({l, l && !err, l && err});
    if (l) nLong++;
    if (l && !err) nOvs++;
    if (l && err) nJab++;
    @(posedge clk);
    frameEnd <= {1'b1, f};
  endtask : sendFrame

  // Results are taken at the negedge before their handshake edge, so once each
  always @(negedge clk) begin
    if (reset_n && bvalid && bready) chkBus(34'(bresp), 34'(respQ.pop_front()));
    if (reset_n && rvalid && rready) chkBus({rresp, rdata}, readQ.pop_front());
    if (reset_n && frameClassValid) begin
      chkOut(48'(frameClass), 48'(classQ.pop_front()));
    end
  end

  // Watchdog: the whole sequence needs a few hundred cycles
  initial begin
    #200000;
    nFail++;
    tally_and_finish();
  end

  initial begin
    reset_n = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    {hostTxHeaderPrio, hostRxPacketPrio, port1TxHeaderPrio, fromPort2} = '0;
    frameEnd = '0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 10; i++) axiRead(offs[i], {RESP_OKAY, rsts[i]});
    axiRead(FRAME_CHECK_STATUS_OFS, {RESP_OKAY, 32'h00000000});
    prioSweep(rsts[0], rsts[2], rsts[6], rsts[1]);
    // All ones; the length stays at its ceiling so software limits hold
    for (int i = 0; i < 10; i++) begin
      v = (i == 3) ? (32'hffffc000 | 32'(MAX_LEN_LIMIT)) : 32'hffffffff;
      axiWrite(offs[i], v, 4'hf, RESP_OKAY);
      axiRead(offs[i], {RESP_OKAY, v & masks[i]});
    end
    for (int i = 0; i < 10; i++) begin
      v = (i == 3) ? (32'd100 | (nextRand() & 32'hffffc000)) : nextRand();
      vals[i] = v & masks[i];
      axiWrite(offs[i], v, 4'hf, RESP_OKAY);
      axiRead(offs[i], {RESP_OKAY, vals[i]});
    end
    @(negedge clk);
    chkOut(48'(rxMaxFrameLen), 48'(vals[3][13:0]));
    chkOut(48'(port1TxBlocks), 48'(vals[4][13:9]));
    chkOut(48'(port1RxBlocks), 48'(vals[4][5:0]));
    chkOut(48'(port1DefaultTag), 48'(vals[5][15:0]));
    chkOut(48'(syncMsgKindEnable), 48'(vals[9][31:16]));
    prioSweep(vals[0], vals[2], vals[6], vals[1]);
    // One byte lane only: the other three must keep their old contents
    axiWrite(MAC1_STATION_ADDR_HIGH_OFS, 32'ha5a5a5a5, 4'b0100, RESP_OKAY);
    vals[8][23:16] = 8'ha5;
    axiRead(MAC1_STATION_ADDR_HIGH_OFS, {RESP_OKAY, vals[8]});
    @(negedge clk);
    chkOut(stationAddr, {vals[8][7:0], vals[8][15:8], vals[8][23:16], vals[8][31:24],
                         vals[7][7:0], vals[7][15:8]});
    // Unmapped places refuse and store nothing
    axiWrite(6'h2c, nextRand(), 4'hf, RESP_SLVERR);
    axiRead(6'h2c, {RESP_SLVERR, 32'h00000000});
    axiRead(6'h3c, {RESP_SLVERR, 32'h00000000});
    for (int i = 0; i < 7; i++) sendFrame(frames[i]);
    @(posedge clk);
    frameEnd <= '0;
    repeat (2) @(posedge clk);
    axiRead(FRAME_CHECK_STATUS_OFS, {RESP_OKAY, 8'h00, nJab, nOvs, nLong});
    // A raised maximum governs the very next frame
    axiWrite(HOST_RX_MAX_FRAME_LEN_OFS, 32'd101, 4'hf, RESP_OKAY);
    vals[3] = 32'd101;
    sendFrame({14'd101, 3'b000});
    @(posedge clk);
    frameEnd <= '0;
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule : switch_port_config_regs_tb
